// [bench/match_pwm_assertions.sv]
`timescale 1ns/1ps
// ==========================
// port checker
module match_pwm_chk
(
    // inputs
    input logic        clk,
    input logic        reset,
    input logic        count_run,
    input logic        count_src,
    input logic [6:0]  match_release,
    input logic [5:0]  out_enable,
    // outputs
    input logic [5:0]  pwm_out,
    input logic [31:0] count_value,
    input logic        cycle_start,
    input logic [6:0]  release_pending
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_count_clear: assert property (cycle_start |=> count_value == 0) else $error("no clear");
    a_count_step: assert property (count_run && !count_src && !cycle_start |=>
        count_value == $past(count_value) + 1) else $error("no step");
    a_count_hold: assert property (!count_run |=> $stable(count_value)) else $error("moved");
    a_single_rise: assert property (cycle_start && out_enable[0] |=> pwm_out[0]) else $error("no rise");
    a_rise_cause: assert property ($rose(pwm_out[0]) |-> $past(cycle_start)) else $error("stray rise");
    a_pend_set: assert property (|match_release |=>
        (release_pending & $past(match_release)) == $past(match_release)) else $error("no pend");
    a_pend_apply: assert property (cycle_start |=>
        (release_pending & ~$past(match_release)) == 0) else $error("pend kept");
    a_pend_hold: assert property (!cycle_start |=>
        (release_pending & $past(release_pending)) == $past(release_pending)) else $error("pend lost");
    c_cycle: cover property (cycle_start);
    c_dbl_rise: cover property ($rose(pwm_out[1]));
    c_apply: cover property ($fell(release_pending[1]));
endmodule
bind match_pwm match_pwm_chk match_pwm_chk_inst (.*);

// [bench/pwm_load.sv]
`timescale 1ns/1ps
// ==========================
// load counting turn-on events
module pwm_load
(
    // drive side
    input  logic       clk,
    input  logic       drive,
    // result
    output logic [7:0] ons
);
    logic last_q;
    initial ons = 8'h00;
    always @(posedge clk)
    begin
        last_q <= drive;
        if (drive && !last_q)
            ons <= ons + 8'h01;
    end
endmodule

// [bench/tb_match_pwm.sv]
`timescale 1ns/1ps
module tb_match_pwm;
    logic clk = 0, reset = 1, count_run = 0, count_src = 0, cap_in = 0, cap_on_rise = 0, cap_on_fall = 0;
    logic match_wr = 0, cycle_start;
    logic [2:0] match_sel = 0;
    logic [31:0] match_data = 0, count_value, c0;
    logic [6:0] match_release = 0, release_pending;
    logic [5:0] out_enable = 0, double_edge = 0, pwm_out;
    logic [7:0] ons, a0;
    int failures = 0, num_checks = 0, cyc = 0;
    match_pwm match_pwm_inst (.*);
    pwm_load pwm_load_inst (.clk(clk), .drive(pwm_out[1]), .ons(ons));
    initial
        forever #20 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 1000)
        begin
            failures++;
            give_verdict;
        end
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // strobes stay up; caller drops them
    task wm(input logic [2:0] s, input logic [31:0] d, input logic r);
        match_wr = 1;
        match_sel = s;
        match_data = d;
        match_release = r ? 7'h01 << s : 7'h00;
        @(negedge clk);
    endtask
    task sync;
        repeat (2)
        begin
            @(negedge clk);
            while (cycle_start !== 1'b1)
                @(negedge clk);
        end
    endtask
    // period match 7 (8 counts): rise match r, fall match f
    task per(input int r, input int f, input logic neg);
        while (cycle_start !== 1'b1)
            @(negedge clk);
        for (int i = 0; i < 8; i++)
        begin
            @(negedge clk);
            chk(count_value, i);
            chk(pwm_out[0], i <= r);
            chk(pwm_out[1], (i > (neg ? f : r) && i <= (neg ? r : f)) ^ neg);
            chk(pwm_out[5:2], 4'h0);
        end
    endtask
    task sc_release;
        wm(1, 5, 0);
        wm(2, 2, 0);
        match_wr = 0;
        per(2, 5, 0);
        match_release = 7'h06;
        @(negedge clk);
        match_release = 0;
        chk(release_pending, 7'h06);
        sync;
        chk(release_pending, 0);
        per(5, 2, 1);
    endtask
    task sc_capture;
        count_src = 1;
        cap_on_rise = 1;
        @(negedge clk);
        c0 = count_value;
        repeat (3)
        begin
            cap_in = 1;
            repeat (2) @(negedge clk);
            cap_in = 0;
            repeat (2) @(negedge clk);
        end
        chk(count_value, (c0 + 32'h3) % 32'h8);
        cap_on_rise = 0;
        cap_on_fall = 1;
        @(negedge clk);
        c0 = count_value;
        repeat (2)
        begin
            cap_in = 1;
            repeat (2) @(negedge clk);
            cap_in = 0;
            repeat (2) @(negedge clk);
        end
        chk(count_value, (c0 + 32'h2) % 32'h8);
    endtask
    task give_verdict;
        if (failures == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(negedge clk);
        reset = 0;
        wm(0, 7, 1);
        wm(1, 2, 1);
        wm(2, 5, 1);
        match_wr = 0;
        match_release = 0;
        count_run = 1;
        @(negedge clk);
        out_enable = 6'h03;
        double_edge = 6'h02;
        sync;
        a0 = ons;
        per(2, 5, 0);
        chk(ons - a0, 1);
        sc_release;
        sc_capture;
        give_verdict;
    end
endmodule

// [hw/edge_capture_detect.v]
`timescale 1ns/1ps
module edge_capture_detect
(
    // clock and reset
    input  wire        clk,
    input  wire        reset,
    // capture pin and edge choice
    input  wire        cap_in,
    input  wire        on_rise,
    input  wire        on_fall,
    // result
    output wire        edge_pulse
);
    reg cap_q;

    always @(posedge clk)
    begin
        if (reset)
            cap_q <= 1'b0;
        else
            cap_q <= cap_in;
    end

    assign edge_pulse = (on_rise & cap_in & ~cap_q) | (on_fall & ~cap_in & cap_q);
endmodule

// [hw/match_pwm.v]
// Contract
// - count clears on period match
// - one match register places each single edge
// - single-edge outputs rise at period match
// - extra single-edge output costs one match
// - double-edge uses rise and fall matches
// - extra double-edge output costs two matches
// - fall before rise gives negative pulse
// - all outputs share one repetition rate
// - count on clock or capture edges
// - released match values apply at cycle boundary
`timescale 1ns/1ps
`include "pwm_edge_consts.vh"
module match_pwm
(
    // clock and reset
    input  wire                     clk,
    input  wire                     reset,
    // counter control
    input  wire                     count_run,
    input  wire                     count_src,
    input  wire                     cap_in,
    input  wire                     cap_on_rise,
    input  wire                     cap_on_fall,
    // match programming
    input  wire                     match_wr,
    input  wire [`MSEL_W-1:0]       match_sel,
    input  wire [`CNT_W-1:0]        match_data,
    input  wire [`NUM_MATCH-1:0]    match_release,
    // output configuration, index 1..6 uses bit n-1
    input  wire [`NUM_OUT-1:0]      out_enable,
    input  wire [`NUM_OUT-1:0]      double_edge,
    // outputs
    output wire [`NUM_OUT-1:0]      pwm_out,
    output wire [`CNT_W-1:0]        count_value,
    output wire                     cycle_start,
    output wire [`NUM_MATCH-1:0]    release_pending
);
    // ==========================================
    // shadow and active match registers
    reg  [`CNT_W-1:0]     shadow_q [0:`NUM_MATCH-1];
    reg  [`CNT_W-1:0]     active_q [0:`NUM_MATCH-1];
    reg  [`NUM_MATCH-1:0] pend_q;
    reg  [`CNT_W-1:0]     count_q;
    reg  [`NUM_OUT-1:0]   out_q;
    wire                  tick;
    wire                  cap_edge;
    wire                  period_hit;
    wire [`NUM_MATCH-1:0] hit;

    edge_capture_detect u_cap
    (
        .clk        (clk),
        .reset      (reset),
        .cap_in     (cap_in),
        .on_rise    (cap_on_rise),
        .on_fall    (cap_on_fall),
        .edge_pulse (cap_edge)
    );

    assign tick = count_run & ((count_src == `SRC_PCLK) ? 1'b1 : cap_edge);

    // ==========================================
    // match compare, one per match register
    genvar m;
    generate
        for (m = 0; m < `NUM_MATCH; m = m + 1)
        begin : g_match
            // select code of this match register, sized to the select port
            localparam [`MSEL_W-1:0] SEL_CODE = m;
            assign hit[m] = tick & (count_q == active_q[m]);
            always @(posedge clk)
            begin
                if (reset)
                begin
                    shadow_q[m] <= (m == 0) ? `PERIOD_RST : `MATCH_RST;
                    active_q[m] <= (m == 0) ? `PERIOD_RST : `MATCH_RST;
                    pend_q[m]   <= 1'b0;
                end
                else
                begin
                    if (match_wr && match_sel == SEL_CODE)
                        shadow_q[m] <= match_data;
                    // new values only take effect at the cycle boundary
                    if (period_hit && pend_q[m])
                        active_q[m] <= shadow_q[m];
                    // a release arriving on the boundary wins and stays pending
                    if (match_release[m])
                        pend_q[m] <= 1'b1;
                    else if (period_hit)
                        pend_q[m] <= 1'b0;
                end
            end
        end
    endgenerate

    assign period_hit = hit[0];

    // ==========================================
    // shared counter
    always @(posedge clk)
    begin
        if (reset)
            count_q <= `CNT_START;
        else if (period_hit)
            count_q <= `CNT_START;
        else if (tick)
            count_q <= count_q + 1'b1;
    end

    // ==========================================
    // outputs: single edge uses match n, double edge uses n-1 (rise) and n (fall)
    genvar k;
    generate
        for (k = 1; k <= `NUM_OUT; k = k + 1)
        begin : g_out
            wire set_e;
            wire clr_e;
            if (k >= 2)
            begin : g_dbl_ok
                assign set_e = double_edge[k-1] ? hit[k-1] : period_hit;
            end
            else
            begin : g_single_only
                // output 1 has no rise match of its own, so it is always single edge
                assign set_e = period_hit;
            end
            assign clr_e = hit[k];
            always @(posedge clk)
            begin
                if (reset)
                    out_q[k-1] <= 1'b0;
                else if (!out_enable[k-1])
                    out_q[k-1] <= 1'b0;
                else if (clr_e && !(set_e && double_edge[k-1] && k >= 2))
                    out_q[k-1] <= 1'b0;
                else if (set_e)
                    out_q[k-1] <= 1'b1;
            end
        end
    endgenerate

    assign pwm_out         = out_q;
    assign count_value     = count_q;
    assign cycle_start     = period_hit;
    assign release_pending = pend_q;
endmodule

// [hw/pwm_edge_consts.vh]
`ifndef PWM_EDGE_CONSTS_VH
`define PWM_EDGE_CONSTS_VH

// ==========================================
// sizes
`define CNT_W        32
`define NUM_MATCH    7
`define NUM_OUT      6
`define MSEL_W       3

// ==========================================
// reset values
`define CNT_START    32'h0000_0000
`define PERIOD_RST   32'h0000_0000
`define MATCH_RST    32'h0000_0000
`define ENA_RST      6'h00
`define DBL_RST      6'h00

// ==========================================
// count source
`define SRC_PCLK     1'b0
`define SRC_CAPTURE  1'b1

`endif
